// File: motor_enable_safety_interlock.sv
// Motor enable interlock with safety inputs, fault monitoring and encoder port setup.
`timescale 1ns/10ps
module motor_enable_safety_interlock
(
    input  wire logic                                 clk_in,
    input  wire logic                                 rst_in,
    input  wire logic [1:0]                           safe1_current_in,
    input  wire logic [1:0]                           safe2_current_in,
    input  wire logic                                 overvolt_in,
    input  wire logic [interlock_pkg::NUM_AXES-1:0]   enc_a_lost_in,
    input  wire logic [interlock_pkg::NUM_AXES-1:0]   enc_b_lost_in,
    input  wire logic [interlock_pkg::NUM_AXES-1:0]   enc_z_lost_in,
    input  wire logic [7:0]                           addr_in,
    input  wire logic [31:0]                          wdata_in,
    input  wire logic                                 wr_in,
    input  wire logic                                 rd_in,
    output logic      [31:0]                          rdata_out,
    output logic                                      irq_out,
    output logic      [interlock_pkg::NUM_AXES-1:0]   motor_en_out,
    output logic                                      safety_feedback_out,
    output interlock_pkg::enc_pins_t [interlock_pkg::NUM_AXES-1:0] enc_pins_out
);

    ////////////////////////////////////////////////////////////////////////////////

    logic                                  safe1;
    logic                                  safe2;
    logic                                  both_safe;
    logic [interlock_pkg::NUM_AXES-1:0]    enc_break;
    logic [interlock_pkg::NUM_AXES-1:0]    break_check;
    logic [5:0]                            enc_cfg_reg;
    logic [5:0]                            irq_en_reg;
    logic [5:0]                            irq_stat_reg;
    logic [5:0]                            irq_stat_next;
    logic [5:0]                            event_now;
    logic [5:0]                            cond_reg;
    logic [5:0]                            cond_now;
    logic [31:0]                           status_word;

    // either polarity
    // Each bit stands for current through one of the two input diodes.
    // current means Safe
    // open means Unsafe
    // A floating input carries no current in either diode, so it reads Unsafe.
    assign safe1 = |safe1_current_in;
    assign safe2 = |safe2_current_in;

    assign both_safe = safe1 & safe2;

    assign safety_feedback_out = ~both_safe;

    ////////////////////////////////////////////////////////////////////////////////

    genvar ax;
    generate
        for (ax = 0; ax < interlock_pkg::NUM_AXES; ax++)
        begin : g_axis
            interlock_pkg::enc_type_t etype;
            assign etype = interlock_pkg::enc_type_t'(enc_cfg_reg[2*ax +: 2]);
            assign enc_pins_out[ax].clk_drive_en =
                (etype == interlock_pkg::BISS_ABSOLUTE_TYPE) ||
                (etype == interlock_pkg::SERIAL_ABSOLUTE_TYPE);
            assign enc_pins_out[ax].pair4_is_data    = enc_pins_out[ax].clk_drive_en;
            assign enc_pins_out[ax].pair23_is_sincos =
                (etype == interlock_pkg::SINCOS_INCREMENTAL_TYPE);
            assign break_check[ax] = ~enc_pins_out[ax].clk_drive_en;
            assign enc_pins_out[ax].break_check_en = break_check[ax];
            // index ignored
            // Absolute encoders have no A and B pairs, so no break check is made there.
            assign enc_break[ax] = break_check[ax] & (enc_a_lost_in[ax] | enc_b_lost_in[ax]);
            // enable product
            // Combinational on purpose: a fault drops power without waiting for a clock.
            assign motor_en_out[ax] = both_safe & ~overvolt_in & ~enc_break[ax];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            enc_cfg_reg <= interlock_pkg::ENC_CFG_RESET;
        else if (wr_in && addr_in == interlock_pkg::ENC_CFG_BYTE)
            enc_cfg_reg <= wdata_in[5:0];
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            irq_en_reg <= interlock_pkg::IRQ_EN_RESET;
        else if (wr_in && addr_in == {4'h0, interlock_pkg::ADDR_IRQ_EN})
            irq_en_reg <= wdata_in[5:0];
    end

    // Events: loss of Safe on each channel, over-voltage, and break on each axis.
    assign cond_now = {enc_break, overvolt_in, ~safe2, ~safe1};
    assign event_now = cond_now & ~cond_reg;

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            cond_reg <= 6'h00;
        else
            cond_reg <= cond_now;
    end

    // A new event in the clearing cycle wins over the clear.
    always_comb
    begin
        irq_stat_next = irq_stat_reg;
        if (wr_in && addr_in == {4'h0, interlock_pkg::ADDR_IRQ_CLR})
            irq_stat_next = irq_stat_next & ~wdata_in[5:0];
        irq_stat_next = irq_stat_next | event_now;
    end

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            irq_stat_reg <= 6'h00;
        else
            irq_stat_reg <= irq_stat_next;
    end

    assign irq_out = |(irq_stat_reg & irq_en_reg);

    ////////////////////////////////////////////////////////////////////////////////

    assign status_word = {20'h00000, 1'b0, motor_en_out, 1'b0, enc_break,
                          ~both_safe, overvolt_in, safe2, safe1};

    always_ff @(posedge clk_in)
    begin
        if (rst_in)
            rdata_out <= 32'h00000000;
        else if (rd_in)
        begin
            unique case (addr_in)
                {4'h0, interlock_pkg::ADDR_STATUS}:   rdata_out <= status_word;
                {4'h0, interlock_pkg::ADDR_IRQ_STAT}: rdata_out <= {26'h0, irq_stat_reg};
                {4'h0, interlock_pkg::ADDR_IRQ_EN}:   rdata_out <= {26'h0, irq_en_reg};
                interlock_pkg::ENC_CFG_BYTE:          rdata_out <= {26'h0, enc_cfg_reg};
                default:                              rdata_out <= 32'h00000000;
            endcase
        end
        else
            rdata_out <= 32'h00000000;
    end

endmodule : motor_enable_safety_interlock

// File: interlock_pkg.sv
// Package with constants, types and register map of the motor enable interlock.
package interlock_pkg;

    localparam int unsigned NUM_AXES = 3;
    localparam int unsigned ADDR_W   = 4;
    localparam int unsigned DATA_W   = 32;

    // Register byte addresses.
    localparam logic [ADDR_W-1:0] ADDR_STATUS   = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_STAT = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_CLR  = 4'h8;
    localparam logic [ADDR_W-1:0] ADDR_IRQ_EN   = 4'hc;
    localparam logic [ADDR_W-1:0] ADDR_ENC_TYPE = 4'h0;

    // Live status register fields.
    localparam int unsigned ST_SAFE1     = 0;
    localparam int unsigned ST_SAFE2     = 1;
    localparam int unsigned ST_OVERVOLT  = 2;
    localparam int unsigned ST_FEEDBACK  = 3;
    localparam int unsigned ST_ENC_BREAK = 4;
    localparam int unsigned ST_MOTOR_EN  = 8;

    // Interrupt event bits.
    localparam int unsigned EV_SAFE1_LOST = 0;
    localparam int unsigned EV_SAFE2_LOST = 1;
    localparam int unsigned EV_OVERVOLT   = 2;
    localparam int unsigned EV_ENC_BREAK  = 3;
    localparam int unsigned NUM_EVENTS    = 6;

    // Encoder type register: two bits per axis at offset 0x10.
    localparam logic [ADDR_W-1:0] ADDR_ENC_CFG   = 4'h0;
    localparam logic [7:0]        ENC_CFG_BYTE   = 8'h10;
    localparam logic [5:0]        ENC_CFG_RESET  = 6'h00;
    localparam logic [NUM_EVENTS-1:0] IRQ_EN_RESET = 6'h00;

    typedef enum logic [1:0] {
        QUADRATURE_INCREMENTAL_TYPE = 2'h0,
        SINCOS_INCREMENTAL_TYPE     = 2'h1,
        BISS_ABSOLUTE_TYPE          = 2'h2,
        SERIAL_ABSOLUTE_TYPE        = 2'h3
    } enc_type_t;

    typedef struct packed {
        logic [7:0]        addr;
        logic [DATA_W-1:0] wdata;
        logic              wr;
        logic              rd;
    } reg_req_t;

    // Differential pair usage of one encoder port.
    typedef struct packed {
        logic clk_drive_en;
        logic pair4_is_data;
        logic pair23_is_sincos;
        logic break_check_en;
    } enc_pins_t;

endpackage : interlock_pkg

// File: interlock_checker.sv
// Concurrent checks on the ports of the motor enable interlock.
`timescale 1ns/10ps
module interlock_checker
(
    input wire logic                           clk_in,
    input wire logic                           rst_in,
    input wire logic [1:0]                     safe1_current_in,
    input wire logic [1:0]                     safe2_current_in,
    input wire logic                           overvolt_in,
    input wire logic [2:0]                     enc_a_lost_in,
    input wire logic [2:0]                     enc_b_lost_in,
    input wire logic [7:0]                     addr_in,
    input wire logic [31:0]                    wdata_in,
    input wire logic                           wr_in,
    input wire logic                           rd_in,
    input wire logic [31:0]                    rdata_out,
    input wire logic [2:0]                     motor_en_out,
    input wire logic                           safety_feedback_out,
    input wire interlock_pkg::enc_pins_t [2:0] enc_pins_out
);
    logic       s_ok;
    logic [2:0] brk;
    logic [2:0] roles_ok;
    assign s_ok = (|safe1_current_in) && (|safe2_current_in);
    for (genvar i = 0; i < 3; i++)
    begin : g_ax
        assign brk[i] = enc_pins_out[i].break_check_en & (enc_a_lost_in[i] | enc_b_lost_in[i]);
        assign roles_ok[i] = (enc_pins_out[i].clk_drive_en == enc_pins_out[i].pair4_is_data)
            && !(enc_pins_out[i].clk_drive_en && enc_pins_out[i].break_check_en);
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_cfg_wr; wr_in && addr_in == 8'h10; endsequence
    sequence s_st_rd; rd_in && addr_in == 8'h00; endsequence
    a_both_safe: assert property (!s_ok |-> motor_en_out == 3'h0)
        else $error("motor enabled with a safety input unsafe");
    a_enable_formula: assert property (motor_en_out == ({3{s_ok && !overvolt_in}} & ~brk))
        else $error("motor enable differs from interlock terms");
    a_feedback_level: assert property (safety_feedback_out == !s_ok)
        else $error("safety feedback wrong");
    a_overvolt_off: assert property (overvolt_in |-> motor_en_out == 3'h0)
        else $error("motor enabled during over-voltage");
    a_read_idle: assert property (!rd_in |=> rdata_out == 32'h0)
        else $error("read data outside its cycle");
    a_cfg_absolute: assert property (s_cfg_wr |=>
        enc_pins_out[0].clk_drive_en == $past(wdata_in[1])
        && enc_pins_out[0].break_check_en == !$past(wdata_in[1]))
        else $error("encoder type write not applied");
    a_pair_roles: assert property (&roles_ok)
        else $error("encoder pair roles inconsistent");
    a_status_read: assert property (s_st_rd |=>
        rdata_out[10:8] == $past(motor_en_out)
        && rdata_out[3] == $past(safety_feedback_out))
        else $error("status read wrong");
endmodule : interlock_checker

bind motor_enable_safety_interlock interlock_checker i_chk (.clk_in(clk_in), .rst_in(rst_in),
    .safe1_current_in(safe1_current_in), .safe2_current_in(safe2_current_in),
    .overvolt_in(overvolt_in), .enc_a_lost_in(enc_a_lost_in), .enc_b_lost_in(enc_b_lost_in),
    .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .motor_en_out(motor_en_out),
    .safety_feedback_out(safety_feedback_out), .enc_pins_out(enc_pins_out));

// File: safety_field_model.sv
// External safety circuit model driving the two isolated safety channels.
`timescale 1ns/10ps
module safety_field_model
(
    input  wire logic [1:0] ok_in,
    input  wire logic [1:0] rev_in,
    output logic      [1:0] safe1_current_out,
    output logic      [1:0] safe2_current_out
);
    // Polarity picks the diode; an open channel carries no current.
    assign safe1_current_out = ok_in[0] ? (rev_in[0] ? 2'h2 : 2'h1) : 2'h0;
    assign safe2_current_out = ok_in[1] ? (rev_in[1] ? 2'h2 : 2'h1) : 2'h0;
endmodule : safety_field_model

// File: motor_enable_safety_interlock_tb_top.sv
// Testbench of the motor enable interlock.
`timescale 1ns/10ps
module motor_enable_safety_interlock_tb_top;
    logic clk_in = 0, rst_in = 1, ov = 0, wr = 0, rd = 0;
    logic [1:0] ok = 2'h3, rev = 2'h0, s1, s2;
    logic [2:0] al = 0, bl = 0, zl = 0, men;
    logic [7:0] addr = 0;
    logic [31:0] wd = 0, rdat;
    logic irq, fb;
    interlock_pkg::enc_pins_t [2:0] pins;
    int err_total = 0, n_compared = 0;
    always #10 clk_in = ~clk_in;
    safety_field_model i_field (.ok_in(ok), .rev_in(rev), .safe1_current_out(s1),
        .safe2_current_out(s2));
    motor_enable_safety_interlock i_dut (.clk_in(clk_in), .rst_in(rst_in), .safe1_current_in(s1),
        .safe2_current_in(s2), .overvolt_in(ov), .enc_a_lost_in(al), .enc_b_lost_in(bl),
        .enc_z_lost_in(zl), .addr_in(addr), .wdata_in(wd), .wr_in(wr), .rd_in(rd),
        .rdata_out(rdat), .irq_out(irq), .motor_en_out(men), .safety_feedback_out(fb),
        .enc_pins_out(pins));
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            err_total++;
        end
    endtask : chk
    task wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_in);
        wr <= 1;
        addr <= a;
        wd <= d;
        @(posedge clk_in);
        wr <= 0;
        #1;
    endtask : wr_reg
    task rd_reg(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk_in);
        rd <= 1;
        addr <= a;
        @(posedge clk_in);
        rd <= 0;
        #1 chk("rdata", e, rdat);
    endtask : rd_reg
    task setin(input logic [1:0] o, r, input logic v, input logic [2:0] a, b, z);
        @(posedge clk_in);
        {ok, rev, ov} <= {o, r, v};
        {al, bl, zl} <= {a, b, z};
        #1;
    endtask : setin
    task finish_test;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test
    initial
    begin
        repeat (5000) @(posedge clk_in);
        err_total++;
        finish_test();
    end
    initial
    begin
        repeat (2) @(posedge clk_in);
        rst_in <= 0;
        for (int i = 0; i < 5; i++) rd_reg(8'(i * 4 + 4), 32'h0);
        rd_reg(8'h00, 32'h703);
        for (int i = 0; i < 4; i++)
        begin
            setin(2'h3, 2'(i), 0, 0, 0, 0);
            chk("motor_en", 3'h7, men);
            chk("feedback", 0, fb);
            setin(2'(3 - i), 2'(i), 0, 0, 0, 0);
            chk("motor_en", i ? 3'h0 : 3'h7, men);
            chk("feedback", i != 0, fb);
        end
        wr_reg(8'h08, 32'h3f);
        wr_reg(8'h0c, 32'h3f);
        rd_reg(8'h0c, 32'h3f);
        setin(2'h3, 0, 0, 0, 0, 0);
        chk("irq", 0, irq);
        setin(2'h1, 0, 0, 0, 0, 0);
        rd_reg(8'h00, 32'h009);
        rd_reg(8'h04, 32'h2);
        chk("irq", 1, irq);
        wr_reg(8'h0c, 32'h0);
        chk("irq", 0, irq);
        wr_reg(8'h08, 32'h2);
        rd_reg(8'h04, 32'h0);
        setin(2'h3, 0, 1, 0, 0, 0);
        chk("motor_en", 3'h0, men);
        setin(2'h3, 0, 0, 3'h2, 3'h4, 3'h7);
        chk("motor_en", 3'h1, men);
        rd_reg(8'h00, 32'h163);
        rd_reg(8'h04, 32'h34);
        for (int t = 0; t < 4; t++)
        begin
            wr_reg(8'h10, {26'h0, {3{2'(t)}}});
            chk("pins", t > 1 ? 4'hc : (t ? 4'h3 : 4'h1), pins[1]);
            chk("motor_en", t > 1 ? 3'h7 : 3'h1, men);
        end
        rd_reg(8'h10, 32'h3f);
        finish_test();
    end
endmodule : motor_enable_safety_interlock_tb_top
